// >>> logic/serial_params.svh
`ifndef SERIAL_PARAMS_SVH
`define SERIAL_PARAMS_SVH
// ****************************************
// timing
// ****************************************
`define CLK_HZ          20000000
`define BAUD_BPS        115200
`define BAUD_DIV_RST    16'(((`CLK_HZ) + (`BAUD_BPS) / 2) / (`BAUD_BPS))
`define TICK_MS         1
`define MS_CYC          ((`CLK_HZ) / 1000 * (`TICK_MS))
`define REPLY_MARKER_N_HOLD_BITS 20'h0000A
`define BTN_GAP_MS      10'h1F4
`define BLINK_LAST_MS   10'h3E7
`define ON_IDLE_MS      10'h00A
`define ON_BUSY_MS      10'h064
`define ON_SEND_MS      10'h1F4
`define ON_CMD_MS       10'h384
`define JOIN_PRESSES    3'h2
`define RESTORE_PRESSES 3'h4
`define CTS_MARGIN      2
`define SYNC_RST        4'h7
// ****************************************
// register offsets
// ****************************************
`define REG_CTRL        8'h00
`define REG_PKT_SIZE    8'h04
`define REG_TIMEOUT     8'h08
`define REG_FAULT_MASK  8'h0C
`define REG_FAULT_STAT  8'h10
`define REG_STATUS      8'h14
`define REG_IRQ_STAT    8'h18
`define REG_IRQ_MASK    8'h1C
`define REG_BAUD_DIV    8'h20
// ****************************************
// fields and reset values
// ****************************************
`define CTRL_ACK_EN     0
`define FLT_OVERRUN     0
`define FLT_FRAMING     1
`define FLT_RETRY       2
`define IRQ_EMPTY       0
`define IRQ_FAULT       1
`define IRQ_CMD         2
`define IRQ_BTN         3
`define PKT_SIZE_RST    8'h20
`define TIMEOUT_RST     8'h10
`define FMASK_RST       3'h7
`define IMASK_RST       4'h0
`endif

// >>> logic/serial_pkg.sv
package serial_pkg;
  typedef enum logic [1:0] {TX_IDLE, TX_SEND, TX_WAIT_ACK} send_state_t;
endpackage

// >>> logic/byte_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface byte_link_if;
  logic [7:0] data;
  logic       valid;
  logic       ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> logic/serial_rx.sv
`timescale 1ns/1ps
`default_nettype none
module serial_rx (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        rxd,
  input  wire logic [15:0] bit_div,
  byte_link_if.src         link,
  output logic             ferr
);
  logic        busy_ff, nxt_busy, valid_ff, nxt_valid, ferr_ff, nxt_ferr;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [3:0]  bitn_ff, nxt_bitn;
  logic [7:0]  sh_ff, nxt_sh;

  // start, 8 bits lsb first, stop sampled mid bit
  always_comb begin
    nxt_busy = busy_ff;
    nxt_cnt = cnt_ff;
    nxt_bitn = bitn_ff;
    nxt_sh = sh_ff;
    nxt_valid = 1'b0;
    nxt_ferr = 1'b0;
    if (!busy_ff) begin
      if (!rxd) begin
        nxt_busy = 1'b1;
        nxt_cnt = bit_div >> 1;
        nxt_bitn = 4'h0;
      end
    end else if (cnt_ff == 16'h0000) begin
      nxt_cnt = bit_div - 16'h0001;
      if (bitn_ff == 4'h0) begin
        if (rxd) nxt_busy = 1'b0;  // glitch, not a start bit
        else nxt_bitn = 4'h1;
      end else if (bitn_ff <= 4'h8) begin
        nxt_sh = {rxd, sh_ff[7:1]};
        nxt_bitn = bitn_ff + 4'h1;
      end else begin
        nxt_busy = 1'b0;
        nxt_valid = rxd;
        nxt_ferr = !rxd;
      end
    end else begin
      nxt_cnt = cnt_ff - 16'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      bitn_ff <= 4'h0;
      sh_ff <= 8'h00;
      valid_ff <= 1'b0;
      ferr_ff <= 1'b0;
    end else begin
      busy_ff <= nxt_busy;
      cnt_ff <= nxt_cnt;
      bitn_ff <= nxt_bitn;
      sh_ff <= nxt_sh;
      valid_ff <= nxt_valid;
      ferr_ff <= nxt_ferr;
    end
  end

  assign link.data = sh_ff;
  assign link.valid = valid_ff;
  assign ferr = ferr_ff;
endmodule
`default_nettype wire

// >>> logic/serial_tx.sv
`timescale 1ns/1ps
`default_nettype none
module serial_tx (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [15:0] bit_div,
  byte_link_if.snk         link,
  output logic             txd
);
  logic [9:0]  sh_ff, nxt_sh;
  logic [3:0]  n_ff, nxt_n;
  logic [15:0] cnt_ff, nxt_cnt;
  logic        txd_ff, nxt_txd;

  // frame is stop, data lsb first, start; shifted out from bit 0
  always_comb begin
    nxt_sh = sh_ff;
    nxt_n = n_ff;
    nxt_cnt = cnt_ff;
    if (n_ff == 4'h0) begin
      if (link.valid) begin
        nxt_sh = {1'b1, link.data, 1'b0};
        nxt_n = 4'hA;
        nxt_cnt = bit_div - 16'h0001;
      end
    end else if (cnt_ff == 16'h0000) begin
      nxt_sh = {1'b1, sh_ff[9:1]};
      nxt_n = n_ff - 4'h1;
      nxt_cnt = bit_div - 16'h0001;
    end else begin
      nxt_cnt = cnt_ff - 16'h0001;
    end
    nxt_txd = (nxt_n != 4'h0) ? nxt_sh[0] : 1'b1;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sh_ff <= 10'h3FF;
      n_ff <= 4'h0;
      cnt_ff <= 16'h0000;
      txd_ff <= 1'b1;
    end else begin
      sh_ff <= nxt_sh;
      n_ff <= nxt_n;
      cnt_ff <= nxt_cnt;
      txd_ff <= nxt_txd;
    end
  end

  assign link.ready = (n_ff == 4'h0);
  assign txd = txd_ff;
endmodule
`default_nettype wire

// >>> logic/host_serial_indicator_interface.sv
// Notes on behaviour
// - buffer-empty high when input buffer is empty
// - with ack on, empty waits for ack/retry fault
// - enabled exception types raise the fault output
// - reading fault status drops the fault output
// - reply marker low while output carries replies
// - one serial output for replies and air data
// - mode-select low: input bytes are commands
// - mode-select high: input bytes are payload
// - clear-to-send low only when room remains
// - reset low holds device in reset
// - power-down low stops intake, new packets, new serial frames and presses; registers still work
// - activity pulse length encodes operating state
// - payload bytes never reach the command path
// - launch packet on byte count or idle timeout
`timescale 1ns/1ps
`default_nettype none
`include "serial_params.svh"
module host_serial_indicator_interface #(
  parameter int DEPTH     = 64,
  parameter int MS_CYCLES = `MS_CYC
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        serial_in,
  input  wire logic        mode_sel_n,
  input  wire logic        power_down_n,
  input  wire logic        button_in,
  output logic             serial_out,
  output logic             tx_buffer_empty,
  output logic             fault_flag_out,
  output logic             reply_marker_n,
  output logic             cts_n,
  output logic             activity_indicator,
  output logic             irq,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  output logic      [7:0]  radio_data,
  output logic             radio_valid,
  output logic             radio_last,
  input  wire logic        radio_ready,
  input  wire logic        radio_ack,
  input  wire logic        radio_retry_fail,
  input  wire logic [7:0]  air_data,
  input  wire logic        air_valid,
  input  wire logic [7:0]  reply_data,
  input  wire logic        reply_valid,
  output logic      [7:0]  cmd_data,
  output logic             cmd_valid,
  output logic             join_req,
  output logic             restore_req
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  localparam int MW = $clog2(MS_CYCLES);

  // ****************************************
  // pin synchronisers and serial engines
  // ****************************************
  logic [3:0] sync1_ff, sync2_ff;
  logic       rx_s, mode_s, run, btn_s, ferr;
  byte_link_if rx_l ();
  byte_link_if tx_l ();
  logic [15:0] baud_div_ff;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_ff <= `SYNC_RST;
      sync2_ff <= `SYNC_RST;
    end else begin
      sync1_ff <= {button_in, power_down_n, mode_sel_n, serial_in};
      sync2_ff <= sync1_ff;
    end
  end
  assign rx_s = sync2_ff[0];
  assign mode_s = sync2_ff[1];
  assign run = sync2_ff[2];
  assign btn_s = sync2_ff[3];
  assign rx_l.ready = 1'b1;

  serial_rx u_rx (.clk(clk), .nrst(nrst), .rxd(rx_s), .bit_div(baud_div_ff), .link(rx_l), .ferr(ferr));
  serial_tx u_tx (.clk(clk), .nrst(nrst), .bit_div(baud_div_ff), .link(tx_l), .txd(serial_out));

  // ****************************************
  // payload buffer and packet launch
  // ****************************************
  logic [7:0]  mem [DEPTH];
  logic [AW-1:0] wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic [CW-1:0] count_ff, nxt_count;
  logic [7:0]  left_ff, nxt_left, idle_ms_ff, nxt_idle, pkt_size_ff, timeout_ff;
  logic [7:0]  nxt_radio_data;
  logic        nxt_radio_valid, nxt_radio_last, nxt_empty, nxt_cts_n, ack_en_ff, ms_tick_ff;
  logic        push, pop, overrun;
  serial_pkg::send_state_t state_ff, nxt_state;

  assign push = rx_l.valid && mode_s && run && (count_ff < CW'(DEPTH));
  assign overrun = rx_l.valid && mode_s && run && (count_ff >= CW'(DEPTH));

  // packet assembly; buffer word leaves only when the radio takes it
  always_comb begin
    nxt_state = state_ff;
    nxt_rd = rd_ff;
    nxt_wr = push ? wr_ff + AW'(1) : wr_ff;
    nxt_left = left_ff;
    nxt_radio_valid = radio_valid;
    nxt_radio_data = radio_data;
    nxt_radio_last = radio_last;
    nxt_idle = idle_ms_ff;
    pop = 1'b0;
    if (push) nxt_idle = 8'h00;
    else if (ms_tick_ff && idle_ms_ff != 8'hFF) nxt_idle = idle_ms_ff + 8'h01;
    case (state_ff)
      serial_pkg::TX_IDLE: begin
        if (run && count_ff != '0 && (8'(count_ff) >= pkt_size_ff || idle_ms_ff >= timeout_ff)) begin
          nxt_state = serial_pkg::TX_SEND;
          nxt_left = (pkt_size_ff == 8'h00 || 8'(count_ff) < pkt_size_ff) ? 8'(count_ff) : pkt_size_ff;
          nxt_radio_valid = 1'b1;
          nxt_radio_data = mem[rd_ff];
          nxt_radio_last = (nxt_left == 8'h01);
        end
      end
      serial_pkg::TX_SEND: begin
        if (radio_valid && radio_ready) begin
          pop = 1'b1;
          nxt_rd = rd_ff + AW'(1);
          nxt_left = left_ff - 8'h01;
          if (left_ff == 8'h01) begin
            nxt_radio_valid = 1'b0;
            nxt_radio_last = 1'b0;
            nxt_state = ack_en_ff ? serial_pkg::TX_WAIT_ACK : serial_pkg::TX_IDLE;
          end else begin
            nxt_radio_data = mem[nxt_rd];
            nxt_radio_last = (left_ff == 8'h02);
          end
        end
      end
      serial_pkg::TX_WAIT_ACK: begin
        if (radio_ack || radio_retry_fail) nxt_state = serial_pkg::TX_IDLE;
      end
      default: nxt_state = serial_pkg::TX_IDLE;
    endcase
    nxt_count = CW'(count_ff + CW'(push) - CW'(pop));
    nxt_empty = (nxt_count == '0) && (nxt_state != serial_pkg::TX_WAIT_ACK);
    // margin covers a byte already on the wire when the flag flips
    nxt_cts_n = !(run && nxt_count < CW'(DEPTH - `CTS_MARGIN));
  end

  always_ff @(posedge clk) begin
    if (push) mem[wr_ff] <= rx_l.data;
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_ff <= serial_pkg::TX_IDLE;
      wr_ff <= '0;
      rd_ff <= '0;
      count_ff <= '0;
      left_ff <= 8'h00;
      idle_ms_ff <= 8'h00;
      radio_valid <= 1'b0;
      radio_data <= 8'h00;
      radio_last <= 1'b0;
      tx_buffer_empty <= 1'b1;
      cts_n <= 1'b1;
    end else begin
      state_ff <= nxt_state;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      count_ff <= nxt_count;
      left_ff <= nxt_left;
      idle_ms_ff <= nxt_idle;
      radio_valid <= nxt_radio_valid;
      radio_data <= nxt_radio_data;
      radio_last <= nxt_radio_last;
      tx_buffer_empty <= nxt_empty;
      cts_n <= nxt_cts_n;
    end
  end

  // ****************************************
  // serial output: replies and air data
  // ****************************************
  logic [7:0]  rep_ff, air_ff;
  logic        rep_full_ff, air_full_ff, nxt_rep_full, nxt_air_full, nxt_marker;
  logic        load, sel_rep;
  logic [19:0] hold_ff, nxt_hold;

  // air bytes wait while the marker is low so it never mislabels one
  assign sel_rep = rep_full_ff;
  assign tx_l.valid = run && (rep_full_ff || (air_full_ff && reply_marker_n));
  assign tx_l.data = sel_rep ? rep_ff : air_ff;
  assign load = tx_l.valid && tx_l.ready;

  always_comb begin
    nxt_rep_full = (rep_full_ff && !(load && sel_rep)) || reply_valid;
    nxt_air_full = (air_full_ff && !(load && !sel_rep)) || air_valid;
    nxt_marker = reply_marker_n;
    nxt_hold = hold_ff;
    if (load && sel_rep) begin
      nxt_marker = 1'b0;
      nxt_hold = 20'(`REPLY_MARKER_N_HOLD_BITS * baud_div_ff);
    end else if (!reply_marker_n && tx_l.ready && !rep_full_ff) begin
      if (hold_ff != 20'h00000) nxt_hold = hold_ff - 20'h00001;
      else nxt_marker = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      rep_full_ff <= 1'b0;
      air_full_ff <= 1'b0;
      rep_ff <= 8'h00;
      air_ff <= 8'h00;
      reply_marker_n <= 1'b1;
      hold_ff <= 20'h00000;
    end else begin
      rep_full_ff <= nxt_rep_full;
      air_full_ff <= nxt_air_full;
      if (reply_valid) rep_ff <= reply_data;
      if (air_valid) air_ff <= air_data;
      reply_marker_n <= nxt_marker;
      hold_ff <= nxt_hold;
    end
  end

  // ****************************************
  // registers, faults and interrupt
  // ****************************************
  logic [2:0] fault_ev, fmask_ff, fstat_ff, nxt_fstat, nxt_fmask;
  logic [3:0] irq_ev, istat_ff, imask_ff, nxt_istat, nxt_imask;
  logic [7:0] nxt_pkt, nxt_tmo;
  logic [15:0] nxt_baud;
  logic [31:0] nxt_rdata;
  logic       nxt_ack_en, nxt_fault, nxt_irq, nxt_cmd_valid, fault_rd, btn_ev;

  assign fault_ev = {radio_retry_fail && state_ff == serial_pkg::TX_WAIT_ACK, ferr, overrun};
  assign fault_rd = reg_rd && (reg_addr == `REG_FAULT_STAT);
  assign irq_ev = {btn_ev, nxt_cmd_valid, |fault_ev, nxt_empty && !tx_buffer_empty};
  assign nxt_cmd_valid = rx_l.valid && !mode_s && run;

  // status bits: a new event in the clearing cycle survives
  always_comb begin
    nxt_ack_en = ack_en_ff;
    nxt_pkt = pkt_size_ff;
    nxt_tmo = timeout_ff;
    nxt_fmask = fmask_ff;
    nxt_imask = imask_ff;
    nxt_baud = baud_div_ff;
    nxt_istat = istat_ff;
    nxt_rdata = 32'h00000000;
    if (restore_req) begin
      nxt_ack_en = 1'b0;
      nxt_pkt = `PKT_SIZE_RST;
      nxt_tmo = `TIMEOUT_RST;
      nxt_fmask = `FMASK_RST;
      nxt_baud = `BAUD_DIV_RST;
    end else if (reg_wr) begin
      if (reg_addr == `REG_CTRL) nxt_ack_en = reg_wdata[`CTRL_ACK_EN];
      else if (reg_addr == `REG_PKT_SIZE) nxt_pkt = reg_wdata[7:0];
      else if (reg_addr == `REG_TIMEOUT) nxt_tmo = reg_wdata[7:0];
      else if (reg_addr == `REG_FAULT_MASK) nxt_fmask = reg_wdata[2:0];
      else if (reg_addr == `REG_IRQ_STAT) nxt_istat = istat_ff & ~reg_wdata[3:0];
      else if (reg_addr == `REG_IRQ_MASK) nxt_imask = reg_wdata[3:0];
      else if (reg_addr == `REG_BAUD_DIV) nxt_baud = reg_wdata[15:0];
    end
    nxt_istat = nxt_istat | irq_ev;
    nxt_fstat = (fault_rd ? 3'h0 : fstat_ff) | fault_ev;
    nxt_fault = (|(fault_ev & fmask_ff)) || (fault_flag_out && !fault_rd);
    nxt_irq = |(nxt_istat & nxt_imask);
    if (reg_rd) begin
      if (reg_addr == `REG_CTRL) nxt_rdata = 32'(ack_en_ff);
      else if (reg_addr == `REG_PKT_SIZE) nxt_rdata = 32'(pkt_size_ff);
      else if (reg_addr == `REG_TIMEOUT) nxt_rdata = 32'(timeout_ff);
      else if (reg_addr == `REG_FAULT_MASK) nxt_rdata = 32'(fmask_ff);
      else if (reg_addr == `REG_FAULT_STAT) nxt_rdata = 32'(fstat_ff);
      else if (reg_addr == `REG_STATUS)
        nxt_rdata = 32'({state_ff, 8'(count_ff), tx_buffer_empty, cts_n, fault_flag_out, !mode_s});
      else if (reg_addr == `REG_IRQ_STAT) nxt_rdata = 32'(istat_ff);
      else if (reg_addr == `REG_IRQ_MASK) nxt_rdata = 32'(imask_ff);
      else if (reg_addr == `REG_BAUD_DIV) nxt_rdata = 32'(baud_div_ff);
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_en_ff <= 1'b0;
      pkt_size_ff <= `PKT_SIZE_RST;
      timeout_ff <= `TIMEOUT_RST;
      fmask_ff <= `FMASK_RST;
      imask_ff <= `IMASK_RST;
      baud_div_ff <= `BAUD_DIV_RST;
      istat_ff <= 4'h0;
      fstat_ff <= 3'h0;
      fault_flag_out <= 1'b0;
      irq <= 1'b0;
      reg_rdata <= 32'h00000000;
      cmd_valid <= 1'b0;
      cmd_data <= 8'h00;
    end else begin
      ack_en_ff <= nxt_ack_en;
      pkt_size_ff <= nxt_pkt;
      timeout_ff <= nxt_tmo;
      fmask_ff <= nxt_fmask;
      imask_ff <= nxt_imask;
      baud_div_ff <= nxt_baud;
      istat_ff <= nxt_istat;
      fstat_ff <= nxt_fstat;
      fault_flag_out <= nxt_fault;
      irq <= nxt_irq;
      reg_rdata <= nxt_rdata;
      cmd_valid <= nxt_cmd_valid;
      if (nxt_cmd_valid) cmd_data <= rx_l.data;
    end
  end

  // ****************************************
  // millisecond tick, button, activity
  // ****************************************
  logic [MW-1:0] ms_cnt_ff, nxt_ms_cnt;
  logic [9:0]    gap_ff, nxt_gap, blink_ff, nxt_blink, on_ms;
  logic [2:0]    presses_ff, nxt_presses;
  logic          btn_db_ff, press, nxt_join, nxt_restore, nxt_act;

  assign press = ms_tick_ff && btn_s && !btn_db_ff;  // sampling at 1 ms rides out bounce
  assign btn_ev = join_req || restore_req;

  always_comb begin
    nxt_ms_cnt = (ms_cnt_ff == MW'(MS_CYCLES - 1)) ? '0 : ms_cnt_ff + MW'(1);
    nxt_presses = presses_ff;
    nxt_gap = gap_ff;
    nxt_join = 1'b0;
    nxt_restore = 1'b0;
    if (!run) begin
      nxt_presses = 3'h0;
      nxt_gap = 10'h000;
    end else if (press) begin
      nxt_presses = (presses_ff == 3'h7) ? presses_ff : presses_ff + 3'h1;
      nxt_gap = 10'h000;
    end else if (ms_tick_ff && presses_ff != 3'h0) begin
      if (gap_ff == `BTN_GAP_MS) begin
        nxt_join = (presses_ff == `JOIN_PRESSES);
        nxt_restore = (presses_ff == `RESTORE_PRESSES);
        nxt_presses = 3'h0;
        nxt_gap = 10'h000;
      end else begin
        nxt_gap = gap_ff + 10'h001;
      end
    end
    nxt_blink = blink_ff;
    if (ms_tick_ff) nxt_blink = (blink_ff == `BLINK_LAST_MS) ? 10'h000 : blink_ff + 10'h001;
    if (!mode_s) on_ms = `ON_CMD_MS;
    else if (state_ff != serial_pkg::TX_IDLE) on_ms = `ON_SEND_MS;
    else if (count_ff != '0) on_ms = `ON_BUSY_MS;
    else on_ms = `ON_IDLE_MS;
    nxt_act = run && (blink_ff < on_ms);
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ms_cnt_ff <= '0;
      ms_tick_ff <= 1'b0;
      btn_db_ff <= 1'b0;
      presses_ff <= 3'h0;
      gap_ff <= 10'h000;
      blink_ff <= 10'h000;
      join_req <= 1'b0;
      restore_req <= 1'b0;
      activity_indicator <= 1'b0;
    end else begin
      ms_cnt_ff <= nxt_ms_cnt;
      ms_tick_ff <= (ms_cnt_ff == MW'(MS_CYCLES - 1));
      if (ms_tick_ff) btn_db_ff <= btn_s;
      presses_ff <= nxt_presses;
      gap_ff <= nxt_gap;
      blink_ff <= nxt_blink;
      join_req <= nxt_join;
      restore_req <= nxt_restore;
      activity_indicator <= nxt_act;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  empty_flag_a: assert property (tx_buffer_empty == (count_ff == '0 && state_ff != serial_pkg::TX_WAIT_ACK))
    else $error("buffer empty flag disagrees with buffer");
  ack_hold_a: assert property (state_ff == serial_pkg::TX_WAIT_ACK |-> !tx_buffer_empty)
    else $error("empty shown before acknowledge");
  fault_raise_a: assert property (|(fault_ev & fmask_ff) |=> fault_flag_out)
    else $error("enabled fault not flagged");
  fault_clear_a: assert property (fault_rd && !(|(fault_ev & fmask_ff)) |=> !fault_flag_out)
    else $error("fault flag survived status read");
  reply_mark_a: assert property (load && sel_rep |=> !reply_marker_n [*2])
    else $error("reply byte sent without marker");
  cmd_route_a: assert property (rx_l.valid && run |=> cmd_valid == !$past(mode_s))
    else $error("byte routed to wrong path");
  cts_room_a: assert property (!cts_n |-> count_ff < CW'(DEPTH - `CTS_MARGIN))
    else $error("clear to send without room");
  pd_quiet_a: assert property (!run |=> cts_n && !activity_indicator && !cmd_valid)
    else $error("activity during power down");
  launch_pkt_a: assert property (state_ff == serial_pkg::TX_IDLE && run && count_ff != '0 &&
                                 8'(count_ff) >= pkt_size_ff |=> radio_valid)
    else $error("full packet not launched");

  launch_c: cover property (state_ff == serial_pkg::TX_SEND ##[1:200] state_ff == serial_pkg::TX_WAIT_ACK);
  reply_c: cover property (load && sel_rep);
  join_c: cover property (join_req);
endmodule
`default_nettype wire

// >>> sim/host_uart_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****
// host side of the serial port
// ****
module host_uart_model (
  input  wire logic        clk,
  input  wire logic        cts_n,
  input  wire logic [15:0] bit_div,
  output logic             line
);
  initial line = 1'b1;
  // one frame; holds off while the device has no room
  task automatic send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    while (cts_n !== 1'b0) @(posedge clk);
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) line <= f[i];
      repeat (bit_div - 1) @(posedge clk);
    end
  endtask
endmodule
`default_nettype wire

// >>> sim/host_serial_indicator_interface_tb.sv
`timescale 1ns/1ps
`default_nettype none
module host_serial_indicator_interface_tb;
  // ****
  // signals, design and host
  // ****
  logic clk = 1'b0, nrst = 1'b0, mode_sel_n = 1'b1, power_down_n = 1'b1;
  logic button_in = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, radio_ready = 1'b1;
  logic radio_ack = 1'b0, radio_retry_fail = 1'b0, air_valid = 1'b0;
  logic reply_valid = 1'b0, serial_in;
  logic [7:0] reg_addr = 8'h00, air_data = 8'h00, reply_data = 8'h00;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic serial_out, tx_buffer_empty, fault_flag_out, reply_marker_n, cts_n;
  logic activity_indicator, irq, radio_valid, radio_last, cmd_valid;
  logic join_req, restore_req;
  logic [7:0] radio_data, cmd_data;
  logic [8:0] rq[$];
  int checks = 0, err_count = 0, ncmd = 0, njoin = 0, nrest = 0;
  localparam logic [15:0] DIV = 16'h0008;
  host_serial_indicator_interface #(.MS_CYCLES(20)) DUT (.clk, .nrst, .serial_in,
    .mode_sel_n, .power_down_n, .button_in, .serial_out, .tx_buffer_empty,
    .fault_flag_out, .reply_marker_n, .cts_n, .activity_indicator, .irq, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .radio_data, .radio_valid, .radio_last,
    .radio_ready, .radio_ack, .radio_retry_fail, .air_data, .air_valid, .reply_data,
    .reply_valid, .cmd_data, .cmd_valid, .join_req, .restore_req);
  host_uart_model host (.clk, .cts_n, .bit_div(DIV), .line(serial_in));
  always #25 clk = ~clk;
  // one-cycle pulses are caught here so tasks may look later
  always @(posedge clk) begin
    if (cmd_valid === 1'b1) ncmd <= ncmd + 1;
    if (join_req === 1'b1) njoin <= njoin + 1;
    if (restore_req === 1'b1) nrest <= nrest + 1;
    if (radio_valid === 1'b1 && radio_ready === 1'b1) rq.push_back({radio_last, radio_data});
  end
  // ****
  // shared tasks
  // ****
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s exp %h seen %h", n, exp, seen);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    idle(1);
    reg_wr <= 1'b0;
  endtask
  // data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    idle(1);
    reg_rd <= 1'b0;
    rv = reg_rdata;
  endtask
  task automatic close_out;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_reset;
    idle(2);
    chk("rst outs", {serial_out, tx_buffer_empty, cts_n, reply_marker_n, irq}, 32'h1E);
    @(posedge clk) nrst <= 1'b1;
    idle(12);
    chk("cts", cts_n, 1'b0);
    wr(8'h20, {16'h0, DIV});
  endtask
  task automatic t_cmd;
    wr(8'h1C, 32'h4);
    mode_sel_n <= 1'b0;
    idle(4);
    host.send(8'hA5);
    // long wait so the blink counter is past the idle on-time
    idle(200);
    chk("cmd byte", cmd_data, 8'hA5);
    chk("cmd cnt", ncmd, 1);
    chk("no radio", rq.size(), 0);
    chk("act cmd", activity_indicator, 1'b1);
    chk("irq", irq, 1'b1);
    wr(8'h18, 32'h4);
    idle(2);
    chk("irq clr", irq, 1'b0);
  endtask
  task automatic t_data;
    wr(8'h04, 32'h2);
    mode_sel_n <= 1'b1;
    idle(4);
    host.send(8'h3C);
    idle(20);
    chk("not empty", tx_buffer_empty, 1'b0);
    host.send(8'h81);
    idle(20);
    chk("pkt", {rq[0], rq[1]}, {9'h03C, 9'h181});
    chk("no cmd", ncmd, 1);
    chk("empty", tx_buffer_empty, 1'b1);
    chk("act idle", activity_indicator, 1'b0);
    host.send(8'h11);
    idle(400);
    chk("tmo pkt", rq[2], 9'h111);
  endtask
  // with ack on, empty waits for the retry fault
  task automatic t_ack;
    wr(8'h00, 32'h1);
    wr(8'h04, 32'h1);
    host.send(8'h5A);
    idle(20);
    chk("ack wait", tx_buffer_empty, 1'b0);
    chk("ack pkt", rq[3], 9'h15A);
    radio_retry_fail <= 1'b1;
    idle(1);
    radio_retry_fail <= 1'b0;
    idle(3);
    chk("retry empty", tx_buffer_empty, 1'b1);
    chk("fault up", fault_flag_out, 1'b1);
    rd(8'h10);
    chk("fault stat", rv, 32'h4);
    idle(2);
    chk("fault down", fault_flag_out, 1'b0);
  endtask
  // two presses then the long gap ask for a join, not a restore
  task automatic t_btn;
    repeat (2) begin
      button_in <= 1'b1;
      idle(60);
      button_in <= 1'b0;
      idle(60);
    end
    idle(10100);
    chk("join", njoin, 32'h1);
    chk("restore", nrest, 32'h0);
  endtask
  task automatic t_reply;
    reply_data <= 8'hC3;
    reply_valid <= 1'b1;
    idle(1);
    reply_valid <= 1'b0;
    idle(3);
    chk("marker", reply_marker_n, 1'b0);
    chk("start bit", serial_out, 1'b0);
    idle(200);
    chk("marker off", reply_marker_n, 1'b1);
    rd(8'hFC);
    chk("unmapped", rv, 32'h0);
    air_data <= 8'h96;
    air_valid <= 1'b1;
    idle(1);
    air_valid <= 1'b0;
    idle(3);
    chk("air start", serial_out, 1'b0);
    chk("air mark", reply_marker_n, 1'b1);
    power_down_n <= 1'b0;
    idle(6);
    chk("pd cts", cts_n, 1'b1);
    chk("pd act", activity_indicator, 1'b0);
  endtask
  initial begin
    t_reset();
    t_cmd();
    t_data();
    t_ack();
    t_btn();
    t_reply();
    close_out();
  end
  // cut a hang short
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    close_out();
  end
endmodule
`default_nettype wire
